// *** core/duas_map.svh ***
// Register offsets, field positions, reset values and timing figures
// Assumes inclusion by the alarm supervisor core module only
`ifndef DUAS_MAP_SVH
`define DUAS_MAP_SVH

// ==========================================================
// Register byte offsets
`define DUAS_OFF_ALARM    8'h00
`define DUAS_OFF_IRQ_STAT 8'h04
`define DUAS_OFF_IRQ_MASK 8'h08
`define DUAS_OFF_BATT_THR 8'h0c
`define DUAS_OFF_CMD      8'h10

// ==========================================================
// Alarm vector bit positions
`define DUAS_UNIT_BITS    3
`define DUAS_B_PILOT_FAIL 0
`define DUAS_B_MODULE_FLT 1
`define DUAS_B_HIGH_TEMP  2
`define DUAS_B_DUAL_SD    6
`define DUAS_B_DUAL_PLO   7
`define DUAS_B_GSD0       8
`define DUAS_B_LOW_BATT   11
`define DUAS_B_PERMISSIVE 12
`define DUAS_NUM_ALARMS   13

// ==========================================================
// Field positions and reset values
`define DUAS_THR_LOW_LSB  0
`define DUAS_THR_OK_LSB   16
`define DUAS_CMD_CLEAR    0
`define DUAS_RST_MASK     13'h1fff
`define DUAS_RST_LOW_THR  12'h000
`define DUAS_RST_OK_THR   12'h000

// ==========================================================
// Timing
`define DUAS_CLK_HZ       200000000
`define DUAS_SEC_S        1
`define DUAS_SEC_PER_MIN  6'd60
`define DUAS_MIN_PER_HR   6'd60
`define DUAS_HR_PER_DAY   5'd24
`define DUAS_DAY_MAX_10   34'h2540be3ff
`define DUAS_DAY_MAX_9    34'h03b9ac9ff

`endif

// *** core/duas_pkg.sv ***
// Types shared by the alarm supervisor and its bench
// Assumes the map header is on the include path
package duas_pkg;

  // ==========================================================
  // Operational state reported by each unit sequencer
  typedef enum logic [3:0] {
    DUAS_US_DISABLED = 4'h0,
    DUAS_US_STOPPED = 4'h1,
    DUAS_US_STARTUP = 4'h2,
    DUAS_US_PREPURGE = 4'h3,
    DUAS_US_IGNITE = 4'h4,
    DUAS_US_PURGE = 4'h5,
    DUAS_US_WAIT = 4'h6,
    DUAS_US_FLAME_PROVING = 4'h7,
    DUAS_US_PILOT_ON = 4'h8,
    DUAS_US_IDLE = 4'h9,
    DUAS_US_PROCESS_ONE_RUNNING = 4'ha
  } duas_unit_state_t;

  // ==========================================================
  // Kind of detail text shown for a unit
  typedef enum logic [2:0] {
    DUAS_DT_NONE = 3'h0,
    DUAS_DT_START_HOLD = 3'h1,
    DUAS_DT_CHECKING = 3'h2,
    DUAS_DT_COUNTDOWN = 3'h3,
    DUAS_DT_PURGE_RETRY = 3'h4,
    DUAS_DT_WAIT_RETRY = 3'h5,
    DUAS_DT_ELAPSED_10 = 3'h6,
    DUAS_DT_ELAPSED_9 = 3'h7
  } duas_detail_kind_t;

  typedef struct packed {
    duas_unit_state_t state;
    logic pilot_fail_cond;
    logic module_lockout;
    logic comm_lost;
    logic shutdown;
    logic high_temp;
    logic [7:0] ignition_attempts_left;
    logic [7:0] wait_retries_left;
    logic [15:0] remain_s;
  } duas_unit_in_t;

  typedef struct packed {
    duas_detail_kind_t kind;
    logic [7:0] retry;
    logic [33:0] days;
    logic [4:0] hh;
    logic [10:0] mm;
    logic [5:0] ss;
  } duas_detail_t;

endpackage : duas_pkg

// *** core/duas_supervisor.sv ***
// Alarm supervisor for a two-unit burner controller, Wishbone register slave
// Assumes one clock, synchronous inputs, sequencers that obey the stop requests
//
// Register access over Wishbone and the placing of the registers were decided locally.
`include "duas_map.svh"

module duas_supervisor #(
  parameter int TICK_CYCLES = `DUAS_CLK_HZ * `DUAS_SEC_S,
  parameter int BATT_W = 12
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Unit status from the sequencers and burner modules
  input duas_pkg::duas_unit_in_t UNIT0_I,
  input duas_pkg::duas_unit_in_t UNIT1_I,
  // System inputs
  input wire logic [2:0] GLOBAL_SHUTDOWN_COND_I,
  input wire logic [BATT_W-1:0] BATTERY_VOLTAGE_INPUT_I,
  input wire logic PERMISSIVE_ACTIVE_I,
  input wire logic OPERATOR_CLEAR_I,
  // Unit control
  output logic [1:0] UNIT_STOP_O,
  output logic [1:0] VALVES_CLOSE_O,
  output logic [1:0] UNIT_TO_STOPPED_O,
  // Alarm indication
  output logic ALARM_O,
  output logic IRQ_O,
  output logic [`DUAS_NUM_ALARMS-1:0] ALARMS_O,
  // Detail text fields
  output duas_pkg::duas_detail_t STATE_DETAIL_TEXT0_O,
  output duas_pkg::duas_detail_t STATE_DETAIL_TEXT1_O
);
  import duas_pkg::*;

  localparam int NA = `DUAS_NUM_ALARMS;
  localparam int UB = `DUAS_UNIT_BITS;

  if (TICK_CYCLES < 1 || BATT_W < 1 || BATT_W > 16) begin : g_chk
    $error("duas_supervisor: unsupported TICK_CYCLES or BATT_W");
  end

  // ==========================================================
  // Helpers
  function automatic logic latch_next(input logic cur, input logic set, input logic rel);
    latch_next = set | (cur & ~rel);
  endfunction

  function automatic logic [16:0] to_mmss(input logic [15:0] s);
    logic [15:0] m;
    logic [15:0] r;
    m = s / 16'd60;
    r = s - m * 16'd60;
    to_mmss = {m[10:0], r[5:0]};
  endfunction

  // ==========================================================
  // Register file and bus
  logic [NA-1:0] alarm_q, alarm_d;
  logic [NA-1:0] irq_stat_q, irq_mask_q;
  logic [BATT_W-1:0] low_thr_q, ok_thr_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic cmd_clear_q;
  logic bus_wr, bus_rd;
  logic [31:0] rd_d;

  assign bus_wr = CYC_I & STB_I & WE_I & ~ack_q;
  assign bus_rd = CYC_I & STB_I & ~WE_I & ~ack_q;

  always_comb begin
    rd_d = 32'h0;
    case (ADR_I)
      `DUAS_OFF_ALARM: rd_d[NA-1:0] = alarm_q;
      `DUAS_OFF_IRQ_STAT: rd_d[NA-1:0] = irq_stat_q;
      `DUAS_OFF_IRQ_MASK: rd_d[NA-1:0] = irq_mask_q;
      `DUAS_OFF_BATT_THR: begin
        rd_d[`DUAS_THR_LOW_LSB +: BATT_W] = low_thr_q;
        rd_d[`DUAS_THR_OK_LSB +: BATT_W] = ok_thr_q;
      end
      default: rd_d = 32'h0;
    endcase
  end

  // Every access, mapped or not, is acked one cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= CYC_I & STB_I & ~ack_q;
      if (bus_rd) begin
        dat_q <= rd_d;
      end
    end
  end

  assign DAT_O = dat_q;
  assign ACK_O = ack_q;

  // Byte lanes of the threshold and mask registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      irq_mask_q <= `DUAS_RST_MASK;
      low_thr_q <= BATT_W'(`DUAS_RST_LOW_THR);
      ok_thr_q <= BATT_W'(`DUAS_RST_OK_THR);
    end else if (bus_wr) begin
      if (ADR_I == `DUAS_OFF_IRQ_MASK) begin
        if (SEL_I[0]) irq_mask_q[7:0] <= DAT_I[7:0];
        if (SEL_I[1]) irq_mask_q[NA-1:8] <= DAT_I[NA-1:8];
      end
      if (ADR_I == `DUAS_OFF_BATT_THR && SEL_I[0] && SEL_I[1]) begin
        low_thr_q <= DAT_I[`DUAS_THR_LOW_LSB +: BATT_W];
      end
      if (ADR_I == `DUAS_OFF_BATT_THR && SEL_I[2] && SEL_I[3]) begin
        ok_thr_q <= DAT_I[`DUAS_THR_OK_LSB +: BATT_W];
      end
    end
  end

  // Software clear acts like the keypad pulse, one cycle later
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cmd_clear_q <= 1'b0;
    end else begin
      cmd_clear_q <= bus_wr && ADR_I == `DUAS_OFF_CMD && SEL_I[0] && DAT_I[`DUAS_CMD_CLEAR];
    end
  end

  // ==========================================================
  // Alarm latches
  duas_unit_in_t u_in [2];
  logic clr;
  logic [NA-1:0] set_v, exit_v;
  logic [1:0] unit_busy_d;
  logic [1:0] pilot_nx;

  assign u_in[0] = UNIT0_I;
  assign u_in[1] = UNIT1_I;
  assign clr = OPERATOR_CLEAR_I | cmd_clear_q;

  always_comb begin
    set_v = '0;
    exit_v = '0;
    for (int u = 0; u < 2; u++) begin
      set_v[UB*u + `DUAS_B_PILOT_FAIL] = u_in[u].pilot_fail_cond;
      exit_v[UB*u + `DUAS_B_PILOT_FAIL] = 1'b1;
      set_v[UB*u + `DUAS_B_MODULE_FLT] = u_in[u].module_lockout | u_in[u].comm_lost;
      exit_v[UB*u + `DUAS_B_MODULE_FLT] = ~u_in[u].module_lockout & ~u_in[u].comm_lost;
      set_v[UB*u + `DUAS_B_HIGH_TEMP] = u_in[u].high_temp;
      exit_v[UB*u + `DUAS_B_HIGH_TEMP] = ~u_in[u].high_temp;
    end
    // Unit next state worked out here, so global bits never loop through alarm_d
    for (int u = 0; u < 2; u++) begin
      unit_busy_d[u] = 1'b0;
      for (int b = 0; b < UB; b++) begin
        unit_busy_d[u] = unit_busy_d[u] |
                         latch_next(alarm_q[UB*u + b], set_v[UB*u + b], clr & exit_v[UB*u + b]);
      end
      pilot_nx[u] = latch_next(alarm_q[UB*u + `DUAS_B_PILOT_FAIL], set_v[UB*u + `DUAS_B_PILOT_FAIL],
                               clr & exit_v[UB*u + `DUAS_B_PILOT_FAIL]);
    end
    set_v[`DUAS_B_DUAL_SD] = u_in[0].shutdown & u_in[1].shutdown;
    // Both unit sets must end up empty in the same clear
    exit_v[`DUAS_B_DUAL_SD] = ~|unit_busy_d;
    // Next pilot bits, so one clear releases pilots and lockout together
    set_v[`DUAS_B_DUAL_PLO] = &pilot_nx;
    exit_v[`DUAS_B_DUAL_PLO] = 1'b1;
    set_v[`DUAS_B_GSD0 +: 3] = GLOBAL_SHUTDOWN_COND_I;
    exit_v[`DUAS_B_GSD0 +: 3] = ~GLOBAL_SHUTDOWN_COND_I;
    set_v[`DUAS_B_LOW_BATT] = BATTERY_VOLTAGE_INPUT_I <= low_thr_q;
    exit_v[`DUAS_B_LOW_BATT] = BATTERY_VOLTAGE_INPUT_I >= ok_thr_q;
    set_v[`DUAS_B_PERMISSIVE] = PERMISSIVE_ACTIVE_I;
    exit_v[`DUAS_B_PERMISSIVE] = ~PERMISSIVE_ACTIVE_I;
  end

  // Set always wins over a clear in the same cycle
  always_comb begin
    for (int i = 0; i < NA; i++) begin
      alarm_d[i] = latch_next(alarm_q[i], set_v[i], clr & exit_v[i]);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  // ==========================================================
  // Unit stop, valves and alarm output
  logic global_d;
  logic [1:0] stop_d;

  assign global_d = |alarm_d[NA-1:2*UB];
  assign stop_d = unit_busy_d | {2{global_d}};

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      UNIT_STOP_O <= 2'h0;
      VALVES_CLOSE_O <= 2'h0;
      UNIT_TO_STOPPED_O <= 2'h0;
      ALARM_O <= 1'b0;
      ALARMS_O <= '0;
    end else begin
      UNIT_STOP_O <= stop_d;
      VALVES_CLOSE_O <= stop_d;
      // Released units go to stopped, not back where they were
      UNIT_TO_STOPPED_O <= UNIT_STOP_O & ~stop_d;
      ALARM_O <= |alarm_d;
      ALARMS_O <= alarm_d;
    end
  end

  // ==========================================================
  // Interrupts: entry into an alarm, write one to clear
  logic [NA-1:0] irq_w1c;

  assign irq_w1c = (bus_wr && ADR_I == `DUAS_OFF_IRQ_STAT) ?
                   {{(NA-8){SEL_I[1]}}, {8{SEL_I[0]}}} & DAT_I[NA-1:0] : '0;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      irq_stat_q <= '0;
      IRQ_O <= 1'b0;
    end else begin
      irq_stat_q <= (alarm_d & ~alarm_q) | (irq_stat_q & ~irq_w1c);
      IRQ_O <= |(((alarm_d & ~alarm_q) | (irq_stat_q & ~irq_w1c)) & irq_mask_q);
    end
  end

  // ==========================================================
  // Elapsed timers and detail text
  logic [31:0] tick_cnt_q;
  logic tick;
  duas_unit_state_t prev_state_q [2];
  logic [5:0] el_ss_q [2];
  logic [5:0] el_mm_q [2];
  logic [4:0] el_hh_q [2];
  logic [33:0] el_dd_q [2];
  duas_detail_t detail_d [2];

  assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

  always_ff @(posedge CLK_I) begin
    if (RST_I || tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  // Counting restarts whenever the unit changes state
  always_ff @(posedge CLK_I) begin
    for (int u = 0; u < 2; u++) begin
      if (RST_I) begin
        prev_state_q[u] <= DUAS_US_DISABLED;
        el_ss_q[u] <= 6'h0;
        el_mm_q[u] <= 6'h0;
        el_hh_q[u] <= 5'h0;
        el_dd_q[u] <= 34'h0;
      end else begin
        prev_state_q[u] <= u_in[u].state;
        if (u_in[u].state != prev_state_q[u]) begin
          el_ss_q[u] <= 6'h0;
          el_mm_q[u] <= 6'h0;
          el_hh_q[u] <= 5'h0;
          el_dd_q[u] <= 34'h0;
        end else if (tick) begin
          el_ss_q[u] <= el_ss_q[u] + 6'h1;
          if (el_ss_q[u] == `DUAS_SEC_PER_MIN - 6'h1) begin
            el_ss_q[u] <= 6'h0;
            el_mm_q[u] <= el_mm_q[u] + 6'h1;
            if (el_mm_q[u] == `DUAS_MIN_PER_HR - 6'h1) begin
              el_mm_q[u] <= 6'h0;
              el_hh_q[u] <= el_hh_q[u] + 5'h1;
              if (el_hh_q[u] == `DUAS_HR_PER_DAY - 5'h1) begin
                el_hh_q[u] <= 5'h0;
                // Days saturate at the widest field; shown value clamps per state
                if (el_dd_q[u] != `DUAS_DAY_MAX_10) begin
                  el_dd_q[u] <= el_dd_q[u] + 34'h1;
                end
              end
            end
          end
        end
      end
    end
  end

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      detail_d[u] = '0;
      {detail_d[u].mm, detail_d[u].ss} = to_mmss(u_in[u].remain_s);
      case (u_in[u].state)
        DUAS_US_STOPPED: detail_d[u].kind = DUAS_DT_START_HOLD;
        DUAS_US_STARTUP: detail_d[u].kind = DUAS_DT_CHECKING;
        DUAS_US_PREPURGE, DUAS_US_IGNITE, DUAS_US_FLAME_PROVING: begin
          detail_d[u].kind = DUAS_DT_COUNTDOWN;
        end
        DUAS_US_PURGE: begin
          detail_d[u].kind = DUAS_DT_PURGE_RETRY;
          detail_d[u].retry = u_in[u].ignition_attempts_left;
        end
        DUAS_US_WAIT: begin
          if (u_in[u].wait_retries_left != 8'h0) begin
            detail_d[u].kind = DUAS_DT_WAIT_RETRY;
            detail_d[u].retry = u_in[u].wait_retries_left;
          end else begin
            detail_d[u].kind = DUAS_DT_NONE;
          end
        end
        DUAS_US_PILOT_ON: begin
          detail_d[u].kind = DUAS_DT_ELAPSED_10;
          detail_d[u].days = el_dd_q[u];
          detail_d[u].hh = el_hh_q[u];
          detail_d[u].mm = {5'h0, el_mm_q[u]};
          detail_d[u].ss = el_ss_q[u];
        end
        DUAS_US_IDLE, DUAS_US_PROCESS_ONE_RUNNING: begin
          detail_d[u].kind = DUAS_DT_ELAPSED_9;
          detail_d[u].days = (el_dd_q[u] > `DUAS_DAY_MAX_9) ? `DUAS_DAY_MAX_9 : el_dd_q[u];
          detail_d[u].hh = el_hh_q[u];
          detail_d[u].mm = {5'h0, el_mm_q[u]};
          detail_d[u].ss = el_ss_q[u];
        end
        default: detail_d[u].kind = DUAS_DT_NONE;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      STATE_DETAIL_TEXT0_O <= '0;
      STATE_DETAIL_TEXT1_O <= '0;
    end else begin
      STATE_DETAIL_TEXT0_O <= detail_d[0];
      STATE_DETAIL_TEXT1_O <= detail_d[1];
    end
  end

endmodule // duas_supervisor

// *** sim/duas_alarm_checker.sv ***
// Port-level checks for the alarm supervisor
// Assumes it is bound onto duas_supervisor; one clock, synchronous reset
module duas_alarm_checker
  import duas_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Watched inputs
  input wire duas_pkg::duas_unit_in_t UNIT0_I,
  input wire duas_pkg::duas_unit_in_t UNIT1_I,
  input wire logic [2:0] GLOBAL_SHUTDOWN_COND_I,
  input wire logic PERMISSIVE_ACTIVE_I,
  input wire logic OPERATOR_CLEAR_I,
  // Watched bus, for the software clear
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic ACK_O,
  // Watched outputs
  input wire logic [1:0] UNIT_STOP_O,
  input wire logic [1:0] VALVES_CLOSE_O,
  input wire logic [1:0] UNIT_TO_STOPPED_O,
  input wire logic ALARM_O,
  input wire logic [12:0] ALARMS_O,
  input wire duas_pkg::duas_detail_t STATE_DETAIL_TEXT0_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // ==========================================================
  // Alarm entry and hold
  perm_set_a: assert property (PERMISSIVE_ACTIVE_I |=> ALARMS_O[12] && ALARM_O && UNIT_STOP_O == 2'b11)
    else $error("permissive alarm not raised");
  perm_hold_a: assert property (ALARMS_O[12] && PERMISSIVE_ACTIVE_I |=> ALARMS_O[12])
    else $error("permissive alarm left while input active");
  gsd_set_a: assert property (|GLOBAL_SHUTDOWN_COND_I |=>
    (ALARMS_O[10:8] & $past(GLOBAL_SHUTDOWN_COND_I)) == $past(GLOBAL_SHUTDOWN_COND_I))
    else $error("global shutdown alarm missing");
  dual_sd_a: assert property (UNIT0_I.shutdown && UNIT1_I.shutdown |=> ALARMS_O[6])
    else $error("dual shutdown alarm missing");
  dual_plo_a: assert property (ALARMS_O[0] && ALARMS_O[3] |-> ALARMS_O[7])
    else $error("dual pilot lockout missing");
  // ==========================================================
  // Unit control
  global_stop_a: assert property (|ALARMS_O[12:6] |-> UNIT_STOP_O == 2'b11 && VALVES_CLOSE_O == 2'b11)
    else $error("global alarm did not stop both units");
  unit_stop_a: assert property (|ALARMS_O[2:0] |-> UNIT_STOP_O[0] && ALARM_O)
    else $error("unit alarm did not stop unit");
  to_stopped_a: assert property ($fell(UNIT_STOP_O[0]) |-> ##[0:1] UNIT_TO_STOPPED_O[0])
    else $error("no stopped pulse after alarm release");
  clear_only_a: assert property ($fell(ALARM_O) |-> $past(OPERATOR_CLEAR_I) ||
    $past(CYC_I && STB_I && WE_I && !ACK_O && ADR_I == 8'h10 && SEL_I[0] && DAT_I[0], 2))
    else $error("alarm released without clear");
  hold_text_a: assert property (UNIT0_I.state == DUAS_US_STOPPED |=> STATE_DETAIL_TEXT0_O.kind == DUAS_DT_START_HOLD)
    else $error("stopped detail text wrong");

  perm_c: cover property (PERMISSIVE_ACTIVE_I ##1 ALARMS_O[12]);
  plo_c: cover property (ALARMS_O[7]);
  gsd_c: cover property (ALARMS_O[10]);
endmodule // duas_alarm_checker

bind duas_supervisor duas_alarm_checker duas_alarm_checker_inst (.CLK_I, .RST_I, .UNIT0_I, .UNIT1_I,
  .GLOBAL_SHUTDOWN_COND_I, .PERMISSIVE_ACTIVE_I, .OPERATOR_CLEAR_I, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I,
  .DAT_I, .ACK_O, .UNIT_STOP_O, .VALVES_CLOSE_O,
  .UNIT_TO_STOPPED_O, .ALARM_O, .ALARMS_O, .STATE_DETAIL_TEXT0_O);

// *** sim/duas_plant_model.sv ***
// Behavioural stand-in for both unit sequencers and burner modules
// Assumes the bench sets unit status through put
module duas_plant_model
  import duas_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Stop requests from the supervisor
  input wire logic [1:0] stop_i,
  // Unit status
  output duas_pkg::duas_unit_in_t unit0_o,
  output duas_pkg::duas_unit_in_t unit1_o
);
  duas_unit_in_t u_q [2] = '{default: '0};
  duas_unit_in_t req_q [2] = '{default: '0};
  logic req_t = 1'b0;
  logic seen_t = 1'b0;

  // Status is presented every cycle, never gapped
  assign unit0_o = u_q[0];
  assign unit1_o = u_q[1];

  // Sequencers obey stop at once; new status lands one edge after put, stop still wins
  always @(posedge clk_i) begin
    seen_t <= req_t;
    for (int k = 0; k < 2; k++) begin
      if (req_t != seen_t) begin
        u_q[k] <= req_q[k];
      end
      if (stop_i[k]) begin
        u_q[k].state <= DUAS_US_STOPPED;
      end
    end
  end

  task automatic put(input duas_unit_in_t a, input duas_unit_in_t b);
    @(posedge clk_i);
    req_q[0] <= a;
    req_q[1] <= b;
    req_t <= ~req_t;
  endtask
endmodule // duas_plant_model

// *** sim/duas_supervisor_bench.sv ***
// Self-checking bench for the alarm supervisor
// Assumes the plant model, checker and package are compiled first
`define DUAS_CHK(g, e) check_val(64'(g), 64'(e))
module duas_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import duas_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, perm = 1'b0, clr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o, rdat;
  logic [2:0] gsd = 3'h0;
  logic [11:0] batt = 12'hfff;
  logic ack, alarm, irq;
  logic [1:0] stop, valves, to_stop, s1;
  logic [12:0] alarms;
  duas_unit_in_t u0, u1;
  duas_unit_in_t uv [2];
  duas_detail_t dt0, dt1;
  int n_fail = 0, total_checks = 0, cycles = 0;
  duas_unit_state_t st [10] = '{DUAS_US_STOPPED, DUAS_US_STARTUP, DUAS_US_PREPURGE, DUAS_US_IGNITE,
    DUAS_US_FLAME_PROVING, DUAS_US_PURGE, DUAS_US_WAIT, DUAS_US_PILOT_ON, DUAS_US_IDLE, DUAS_US_PROCESS_ONE_RUNNING};
  duas_detail_kind_t kd [10] = '{DUAS_DT_START_HOLD, DUAS_DT_CHECKING, DUAS_DT_COUNTDOWN, DUAS_DT_COUNTDOWN,
    DUAS_DT_COUNTDOWN, DUAS_DT_PURGE_RETRY, DUAS_DT_WAIT_RETRY, DUAS_DT_ELAPSED_10, DUAS_DT_ELAPSED_9,
    DUAS_DT_ELAPSED_9};

  always #2.5 clk = ~clk;

  // Short tick keeps elapsed counters visible in a brief run
  duas_supervisor #(.TICK_CYCLES(4), .BATT_W(12)) duas_supervisor_inst (.CLK_I(clk), .RST_I(rst), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .UNIT0_I(u0),
    .UNIT1_I(u1), .GLOBAL_SHUTDOWN_COND_I(gsd), .BATTERY_VOLTAGE_INPUT_I(batt), .PERMISSIVE_ACTIVE_I(perm),
    .OPERATOR_CLEAR_I(clr), .UNIT_STOP_O(stop), .VALVES_CLOSE_O(valves), .UNIT_TO_STOPPED_O(to_stop),
    .ALARM_O(alarm), .IRQ_O(irq), .ALARMS_O(alarms), .STATE_DETAIL_TEXT0_O(dt0), .STATE_DETAIL_TEXT1_O(dt1));
  duas_plant_model duas_plant_model_inst (.clk_i(clk), .stop_i(stop), .unit0_o(u0), .unit1_o(u1));

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic clear_pulse();
    @(posedge clk); clr <= 1'b1;
    @(posedge clk); clr <= 1'b0;
  endtask
  // Release check: stopped pulse may land in either of two cycles
  task automatic released();
    step(1);
    `DUAS_CHK(alarms, 0);
    s1 = to_stop;
    step(1);
    `DUAS_CHK(s1 | to_stop, 2'b11);
  endtask
  task automatic put(input logic [1:0] f);
    duas_plant_model_inst.put(uv[0], uv[1]);
  endtask
  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    step(16); rst <= 1'b0;
    step(1);
    `DUAS_CHK(alarms, 0);
    wb(1'b0, 8'h08, 0); `DUAS_CHK(rdat, 32'h1fff);
    wb(1'b0, 8'h20, 0); `DUAS_CHK(rdat, 0);
    // ==========================================================
    // Permissive, refused clear, interrupt path
    perm <= 1'b1; step(3);
    `DUAS_CHK({alarms, stop, valves, alarm, irq}, {13'h1000, 6'h3f});
    clear_pulse(); perm <= 1'b0; step(2);
    `DUAS_CHK(alarms, 13'h1000);
    wb(1'b0, 8'h04, 0); `DUAS_CHK(rdat, 32'h1000);
    wb(1'b1, 8'h08, 0); step(2); `DUAS_CHK(irq, 0);
    wb(1'b1, 8'h04, 32'h1000); wb(1'b0, 8'h04, 0); `DUAS_CHK(rdat, 0);
    wb(1'b1, 8'h08, 32'h1fff);
    clear_pulse(); released();
    // ==========================================================
    // Global shutdowns one to three
    for (int i = 0; i < 3; i++) begin
      gsd <= 3'(1 << i); step(3);
      `DUAS_CHK({alarms, stop}, {13'(1 << (8 + i)), 2'b11});
      gsd <= 3'h0; clear_pulse(); released();
    end
    // ==========================================================
    // Battery thresholds at their boundaries
    wb(1'b1, 8'h0c, 32'h0200_0100); batt <= 12'h100; step(3);
    `DUAS_CHK(alarms, 13'h0800);
    batt <= 12'h1ff; clear_pulse(); step(1); `DUAS_CHK(alarms, 13'h0800);
    batt <= 12'h200; clear_pulse(); released();
    // Software clear through the command register
    perm <= 1'b1; step(2); perm <= 1'b0; wb(1'b1, 8'h10, 32'h1); released();
    // ==========================================================
    // Unit alarms and dual alarms
    uv[0] = '0; uv[0].pilot_fail_cond = 1'b1; uv[1] = uv[0]; put(2'b11); step(4);
    `DUAS_CHK(alarms, 13'h0089);
    clear_pulse(); step(1); `DUAS_CHK(alarms, 13'h0089);
    uv[0] = '0; uv[1] = '0; put(2'b11); clear_pulse(); step(1);
    `DUAS_CHK(alarms, 0);
    uv[0].module_lockout = 1'b1; uv[0].high_temp = 1'b1; uv[1].comm_lost = 1'b1; put(2'b11); step(3);
    `DUAS_CHK({alarms, stop}, {13'h0016, 2'b11});
    uv[0] = '0; uv[1] = '0; put(2'b11); step(3); `DUAS_CHK(alarms, 13'h0016);
    clear_pulse(); released();
    uv[0].shutdown = 1'b1; uv[1].shutdown = 1'b1; put(2'b11); step(3);
    `DUAS_CHK({alarms, valves}, {13'h0040, 2'b11});
    uv[0] = '0; uv[1] = '0; put(2'b11); clear_pulse(); released();
    // ==========================================================
    // Detail text for every state but disabled
    for (int i = 0; i < 10; i++) begin
      uv[0].state = st[i]; uv[0].remain_s = 16'd125;
      uv[0].ignition_attempts_left = 8'd5; uv[0].wait_retries_left = 8'd3; put(2'b01); step(3);
      `DUAS_CHK(dt0.kind, kd[i]);
      if (kd[i] inside {DUAS_DT_COUNTDOWN, DUAS_DT_PURGE_RETRY, DUAS_DT_WAIT_RETRY}) `DUAS_CHK({dt0.mm, dt0.ss}, 17'h0085);
      if (kd[i] == DUAS_DT_PURGE_RETRY) `DUAS_CHK(dt0.retry, 5);
      if (kd[i] == DUAS_DT_WAIT_RETRY) `DUAS_CHK(dt0.retry, 3);
    end
    step(40);
    `DUAS_CHK({dt0.days, dt0.hh, dt0.mm}, 0);
    `DUAS_CHK(dt0.ss inside {[9:11]}, 1);
    uv[0].state = DUAS_US_WAIT; uv[0].wait_retries_left = 8'd0; uv[1].state = DUAS_US_STARTUP; put(2'b11); step(3);
    `DUAS_CHK(dt0.kind, DUAS_DT_NONE);
    `DUAS_CHK(dt1.kind, DUAS_DT_CHECKING);
    finish_test();
  end
endmodule // duas_supervisor_bench
